// ==== rtl/flash_bus_command_control.sv ====
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_bus_command_control #(
	parameter int ERASE_PULSE_CYCLES = `NS_TO_CYC(`ERASE_PULSE_NS)
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               req_valid,
	input  flash_host_pkg::req_s    req,
	output logic                    req_ready,
	output logic                    resp_valid,
	output flash_host_pkg::resp_s   resp,
	input  wire logic               vpp_enable,
	output logic                    vpp_high,
	output flash_host_pkg::pins_s   pins,
	input  wire logic [`DATA_W-1:0] data_lines_in
);

	localparam int PROG_PULSE_CYCLES = `NS_TO_CYC(`PROG_PULSE_NS);

	function automatic flash_host_pkg::step_s step_of(input flash_host_pkg::op_e op,
		input logic [1:0] idx, input logic [`DATA_W-1:0] wdata);
		flash_host_pkg::step_s s;
		s = '{kind: flash_host_pkg::STEP_READ, data: wdata,
			asel: flash_host_pkg::ASEL_USER, last: 1'b1};
		unique case (op)
			flash_host_pkg::OP_READ: ;
			flash_host_pkg::OP_CMD_WRITE: s.kind = flash_host_pkg::STEP_WRITE;
			flash_host_pkg::OP_READ_ARRAY: begin
				s.kind = flash_host_pkg::STEP_WRITE;
				s.data = `CMD_READ_ARRAY;
			end
			flash_host_pkg::OP_READ_ID_CMD: begin
				s.kind = (idx == 2'h0) ? flash_host_pkg::STEP_WRITE : flash_host_pkg::STEP_READ;
				s.data = `CMD_READ_ID;
				s.asel = (idx == 2'h1) ? flash_host_pkg::ASEL_MAKER : flash_host_pkg::ASEL_DEVICE;
				s.last = (idx == 2'h2);
			end
			flash_host_pkg::OP_READ_ID_HV: begin
				s.asel = (idx == 2'h0) ? flash_host_pkg::ASEL_MAKER : flash_host_pkg::ASEL_DEVICE;
				s.last = (idx == 2'h1);
			end
			flash_host_pkg::OP_ERASE: begin
				s.kind = (idx == 2'h2) ? flash_host_pkg::STEP_WAIT : flash_host_pkg::STEP_WRITE;
				s.data = `CMD_ERASE;
				s.last = (idx == 2'h2);
			end
			flash_host_pkg::OP_PROGRAM: begin
				s.kind = (idx == 2'h2) ? flash_host_pkg::STEP_WAIT : flash_host_pkg::STEP_WRITE;
				s.data = (idx == 2'h0) ? `CMD_PROGRAM : wdata;
				s.last = (idx == 2'h2);
			end
			flash_host_pkg::OP_ERASE_VERIFY, flash_host_pkg::OP_PROGRAM_VERIFY: begin
				s.kind = (idx == 2'h0) ? flash_host_pkg::STEP_WRITE : flash_host_pkg::STEP_READ;
				s.data = (op == flash_host_pkg::OP_ERASE_VERIFY) ? `CMD_ERASE_VERIFY
					: `CMD_PROGRAM_VERIFY;
				s.last = (idx == 2'h1);
			end
			flash_host_pkg::OP_RESET: begin
				s.kind = flash_host_pkg::STEP_WRITE;
				s.data = `CMD_RESET;
				s.last = (idx == 2'h1);
			end
			default: ;
		endcase
		return s;
	endfunction

	function automatic flash_host_pkg::pins_s pins_of(input flash_host_pkg::state_e st,
		input flash_host_pkg::step_s s, input logic [`ADDR_W-1:0] a, input logic hv);
		flash_host_pkg::pins_s p;
		p = '{address_lines: a, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, data_lines_out: '0,
			data_drive_n: 1'b1, identifier_high_voltage: 1'b0};
		if (st == flash_host_pkg::S_SETUP || st == flash_host_pkg::S_STROBE
			|| st == flash_host_pkg::S_HOLD) begin
			p.ce_n = 1'b0;
			p.identifier_high_voltage = hv;
			if (s.asel == flash_host_pkg::ASEL_MAKER) begin
				p.address_lines = `ID_MAKER_ADDR;
			end else if (s.asel == flash_host_pkg::ASEL_DEVICE) begin
				p.address_lines = `ID_DEVICE_ADDR;
			end
			if (s.kind == flash_host_pkg::STEP_WRITE) begin
				// Address and data stand through setup and hold around the strobe
				p.data_lines_out = s.data;
				p.data_drive_n = 1'b0;
				p.we_n = (st != flash_host_pkg::S_STROBE);
			end else begin
				p.oe_n = (st != flash_host_pkg::S_STROBE);
			end
		end
		return p;
	endfunction

	function automatic logic needs_vpp(input flash_host_pkg::op_e op);
		return !(op == flash_host_pkg::OP_READ || op == flash_host_pkg::OP_READ_ID_HV);
	endfunction

	flash_host_pkg::state_e   state;
	flash_host_pkg::state_e   next_state;
	flash_host_pkg::req_s     cur;
	flash_host_pkg::req_s     next_cur;
	logic [1:0]               idx;
	logic [1:0]               next_idx;
	logic [2*`DATA_W-1:0]     rdata;
	logic [2*`DATA_W-1:0]     next_rdata;
	logic                     refused;
	logic                     next_refused;
	logic                     next_vpp_high;
	flash_host_pkg::pins_s    next_pins;
	flash_host_pkg::step_s    step;
	flash_host_pkg::step_s    next_step;
	logic                     timer_load;
	logic [`CNT_W-1:0]        timer_len;
	logic                     expired;

	phase_timer timer (
		.clk     (clk),
		.rst     (rst),
		.load    (timer_load),
		.length  (timer_len),
		.expired (expired)
	);

	always_comb begin
		next_state = state;
		next_cur = cur;
		next_idx = idx;
		next_rdata = rdata;
		next_refused = refused;
		next_vpp_high = vpp_high;
		step = step_of(cur.op, idx, cur.data);
		unique case (state)
			flash_host_pkg::S_IDLE: begin
				next_vpp_high = vpp_enable;
				if (req_valid) begin
					next_cur = req;
					next_idx = 2'h0;
					next_rdata = '0;
					// Alteration commands are withheld while the supply is low
					next_refused = needs_vpp(req.op) && !vpp_high;
					next_state = next_refused ? flash_host_pkg::S_DONE
						: flash_host_pkg::S_SETUP;
				end
			end
			flash_host_pkg::S_SETUP: begin
				if (expired) next_state = flash_host_pkg::S_STROBE;
			end
			flash_host_pkg::S_STROBE: begin
				if (expired) begin
					if (step.kind == flash_host_pkg::STEP_READ) begin
						next_rdata = {rdata[`DATA_W-1:0], data_lines_in};
					end
					next_state = flash_host_pkg::S_HOLD;
				end
			end
			flash_host_pkg::S_HOLD: begin
				if (expired) begin
					if (step.last) begin
						next_state = flash_host_pkg::S_DONE;
					end else begin
						next_idx = idx + 2'h1;
						next_state = (step_of(cur.op, next_idx, cur.data).kind
							== flash_host_pkg::STEP_WAIT) ? flash_host_pkg::S_PULSE
							: flash_host_pkg::S_SETUP;
					end
				end
			end
			flash_host_pkg::S_PULSE: begin
				// Chip select stays high here; the operation carries on deselected
				if (expired) next_state = flash_host_pkg::S_DONE;
			end
			flash_host_pkg::S_DONE: next_state = flash_host_pkg::S_IDLE;
		endcase
		next_step = step_of(next_cur.op, next_idx, next_cur.data);
		next_pins = pins_of(next_state, next_step, next_cur.addr,
			next_cur.op == flash_host_pkg::OP_READ_ID_HV);
		timer_load = (next_state != state) || (next_idx != idx);
		unique case (next_state)
			flash_host_pkg::S_SETUP: timer_len = `CNT_W'(`NS_TO_CYC(`ADDR_SETUP_NS) - 1);
			flash_host_pkg::S_STROBE: timer_len = `CNT_W'(`NS_TO_CYC(`STROBE_NS) - 1);
			flash_host_pkg::S_HOLD: timer_len = `CNT_W'(`NS_TO_CYC(`HOLD_NS) - 1);
			flash_host_pkg::S_PULSE: timer_len = (cur.op == flash_host_pkg::OP_ERASE)
				? `CNT_W'(ERASE_PULSE_CYCLES - 1) : `CNT_W'(PROG_PULSE_CYCLES - 1);
			default: timer_len = '0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= flash_host_pkg::S_IDLE;
			cur <= '0;
			idx <= 2'h0;
			rdata <= '0;
			refused <= 1'b0;
			vpp_high <= 1'b0;
			pins <= '{address_lines: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				data_lines_out: '0, data_drive_n: 1'b1, identifier_high_voltage: 1'b0};
		end else begin
			state <= next_state;
			cur <= next_cur;
			idx <= next_idx;
			rdata <= next_rdata;
			refused <= next_refused;
			vpp_high <= next_vpp_high;
			pins <= next_pins;
		end
	end

	assign req_ready = (state == flash_host_pkg::S_IDLE);
	assign resp_valid = (state == flash_host_pkg::S_DONE);
	assign resp.data = rdata;
	assign resp.refused = refused;
	assign resp.verify_ok = (cur.op == flash_host_pkg::OP_ERASE_VERIFY)
		? (rdata[`DATA_W-1:0] == `ERASED_BYTE) : (rdata[`DATA_W-1:0] == cur.data);

	logic [`DATA_W-1:0] last_wr;
	logic [`DATA_W-1:0] prev_wr;
	logic [`CNT_W-1:0]  pulse_cnt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last_wr <= '0;
			prev_wr <= '0;
			pulse_cnt <= '0;
		end else begin
			if (pins.we_n && !$past(pins.we_n)) begin
				last_wr <= pins.data_lines_out;
				prev_wr <= last_wr;
			end
			pulse_cnt <= (state == flash_host_pkg::S_PULSE) ? pulse_cnt + `CNT_W'(1) : '0;
		end
	end

	data_no_clash_a: assert property (@(posedge clk) disable iff (rst)
		!pins.data_drive_n |-> pins.oe_n && !pins.ce_n)
		else $error("data driven while output gate low");
	write_strobe_a: assert property (@(posedge clk) disable iff (rst)
		!pins.we_n |-> !pins.ce_n && pins.oe_n && vpp_high && !pins.data_drive_n)
		else $error("write strobe without proper select, gate or supply");
	pulse_min_a: assert property (@(posedge clk) disable iff (rst)
		$fell(state == flash_host_pkg::S_PULSE) |-> $past(pulse_cnt) + 1 >=
		((cur.op == flash_host_pkg::OP_ERASE) ? ERASE_PULSE_CYCLES : PROG_PULSE_CYCLES))
		else $error("pulse shorter than minimum");
	erase_twice_a: assert property (@(posedge clk) disable iff (rst)
		$rose(state == flash_host_pkg::S_PULSE) && cur.op == flash_host_pkg::OP_ERASE
		|-> last_wr == `CMD_ERASE && prev_wr == `CMD_ERASE)
		else $error("erase pulse without two erase writes");
	program_setup_a: assert property (@(posedge clk) disable iff (rst)
		$rose(state == flash_host_pkg::S_PULSE) |-> cur.op == flash_host_pkg::OP_ERASE
		|| (prev_wr == `CMD_PROGRAM && last_wr == cur.data))
		else $error("program pulse without setup write");
	read_array_a: assert property (@(posedge clk) disable iff (rst)
		resp_valid && !resp.refused && cur.op == flash_host_pkg::OP_READ_ARRAY
		|-> last_wr == `CMD_READ_ARRAY)
		else $error("read array command not written");
	erase_verify_a: assert property (@(posedge clk) disable iff (rst)
		$fell(pins.oe_n) && cur.op == flash_host_pkg::OP_ERASE_VERIFY
		|-> last_wr == `CMD_ERASE_VERIFY && pins.address_lines == cur.addr)
		else $error("erase verify read without verify command");
	program_verify_a: assert property (@(posedge clk) disable iff (rst)
		$fell(pins.oe_n) && cur.op == flash_host_pkg::OP_PROGRAM_VERIFY
		|-> last_wr == `CMD_PROGRAM_VERIFY ##[1:8] resp_valid)
		else $error("program verify read without verify command");

	erase_done_c: cover property (@(posedge clk) disable iff (rst)
		resp_valid && cur.op == flash_host_pkg::OP_ERASE);
	id_read_c: cover property (@(posedge clk) disable iff (rst)
		resp_valid && cur.op == flash_host_pkg::OP_READ_ID_CMD);
	refused_c: cover property (@(posedge clk) disable iff (rst) resp_valid && resp.refused);
	verify_ok_c: cover property (@(posedge clk) disable iff (rst)
		resp_valid && cur.op == flash_host_pkg::OP_ERASE_VERIFY && resp.verify_ok);

endmodule

// ==== rtl/flash_host_cfg.svh ====
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define ADDR_W 17
`define DATA_W 8
`define CNT_W 24

`define CLK_PERIOD_NS 20
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Bus phase times, minimums
`define ADDR_SETUP_NS 20
`define STROBE_NS 60
`define HOLD_NS 40
`define PROG_PULSE_NS 10000
`define ERASE_PULSE_NS 10000000

`define CMD_READ_ARRAY 8'h00
`define CMD_READ_ID 8'h90
`define CMD_ERASE 8'h20
`define CMD_ERASE_VERIFY 8'hA0
`define CMD_PROGRAM 8'h40
`define CMD_PROGRAM_VERIFY 8'hC0
`define CMD_RESET 8'hFF
`define ERASED_BYTE 8'hFF

`define ID_MAKER_ADDR 17'h00000
`define ID_DEVICE_ADDR 17'h00001

`endif

// ==== rtl/flash_host_pkg.sv ====
`include "flash_host_cfg.svh"

package flash_host_pkg;

	typedef enum logic [3:0] {
		OP_READ, OP_CMD_WRITE, OP_READ_ARRAY, OP_READ_ID_CMD, OP_READ_ID_HV,
		OP_ERASE, OP_ERASE_VERIFY, OP_PROGRAM, OP_PROGRAM_VERIFY, OP_RESET
	} op_e;

	typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_PULSE, S_DONE} state_e;

	typedef enum logic [1:0] {STEP_READ, STEP_WRITE, STEP_WAIT} step_kind_e;

	typedef enum logic [1:0] {ASEL_USER, ASEL_MAKER, ASEL_DEVICE} addr_sel_e;

	typedef struct packed {
		op_e                 op;
		logic [`ADDR_W-1:0]  addr;
		logic [`DATA_W-1:0]  data;
	} req_s;

	typedef struct packed {
		logic [2*`DATA_W-1:0] data;
		logic                 verify_ok;
		logic                 refused;
	} resp_s;

	typedef struct packed {
		step_kind_e          kind;
		logic [`DATA_W-1:0]  data;
		addr_sel_e           asel;
		logic                last;
	} step_s;

	typedef struct packed {
		logic [`ADDR_W-1:0]  address_lines;
		logic                ce_n;
		logic                oe_n;
		logic                we_n;
		logic [`DATA_W-1:0]  data_lines_out;
		logic                data_drive_n;
		logic                identifier_high_voltage;
	} pins_s;

endpackage

// ==== rtl/phase_timer.sv ====
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module phase_timer (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              load,
	input  wire logic [`CNT_W-1:0] length,
	output logic                   expired
);

	logic [`CNT_W-1:0] cnt;
	logic [`CNT_W-1:0] next_cnt;

	always_comb begin
		next_cnt = cnt;
		if (load) begin
			next_cnt = length;
		end else if (cnt != '0) begin
			next_cnt = cnt - `CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign expired = (cnt == '0);

endmodule

// ==== verification/flash_model.sv ====
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_model #(
	parameter logic [7:0] MAKER_CODE  = 8'h3C, // Arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'h6E  // Arbitrary value
) (
	input  flash_host_pkg::pins_s pins,
	input  wire logic             clk,
	input  wire logic             vpp_high,
	output logic [`DATA_W-1:0]    data_lines_in
);
	logic [7:0]  mem [0:255];
	logic [7:0]  cmd;
	logic [7:0]  last;
	logic [7:0]  rd;
	logic [7:0]  wd;
	logic [16:0] wa;
	logic [16:0] va;
	logic        we_q;

	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
		cmd = 8'h00;
		last = 8'h00;
		we_q = 1'b1;
	end

	assign wd = pins.data_lines_out;

	always @(posedge clk) begin
		we_q <= pins.we_n;
		if (!vpp_high) begin
			cmd <= 8'h00;
		end else if (we_q && !pins.we_n) begin
			wa <= pins.address_lines;
		end else if (!we_q && pins.we_n && !pins.ce_n) begin
			if (cmd == 8'h20 && wd == 8'h20) begin
				// Erase completes at once, so a later deselect cannot cut it short
				for (int i = 0; i < 256; i++) mem[i] <= 8'hFF;
				cmd <= 8'h21;
			end else if (cmd == 8'h40) begin
				mem[wa[7:0]] <= mem[wa[7:0]] & wd;
				cmd <= 8'h41;
			end else begin
				cmd <= wd;
				va <= wa;
			end
		end
	end

	always_comb begin
		if (pins.identifier_high_voltage) begin
			rd = pins.address_lines[0] ? DEVICE_CODE : MAKER_CODE;
		end else if (vpp_high && cmd == 8'h90) begin
			rd = pins.address_lines[0] ? DEVICE_CODE : MAKER_CODE;
		end else if (vpp_high && (cmd == 8'hA0 || cmd == 8'hC0)) begin
			rd = mem[va[7:0]];
		end else begin
			rd = mem[pins.address_lines[7:0]];
		end
	end

	// Released lines show the inverse of the last byte, never a stale copy
	assign data_lines_in = (pins.ce_n || pins.oe_n) ? ~last : rd;

	always @(posedge clk) begin
		if (!pins.ce_n && !pins.oe_n) last <= rd;
	end
endmodule

// ==== verification/flash_bus_command_control_tb.sv ====
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_bus_command_control_tb;
	localparam logic [7:0] MAKER  = 8'h3C; // Arbitrary value
	localparam logic [7:0] DEVICE = 8'h6E; // Arbitrary value
	localparam int         LIMIT  = 20000;

	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  req_valid = 1'b0;
	logic                  vpp_enable = 1'b0;
	flash_host_pkg::req_s  req = '0;
	logic                  req_ready;
	logic                  resp_valid;
	flash_host_pkg::resp_s resp;
	flash_host_pkg::resp_s got;
	logic                  vpp_high;
	flash_host_pkg::pins_s pins;
	logic [`DATA_W-1:0]    data_lines_in;
	int                    err_total = 0;
	int                    samples_checked = 0;
	int                    cycles = 0;
	int                    ref_mem [256];
	int                    vpp_ref = 0;
	logic [16:0]           pa [3];
	logic [7:0]            pd [3];

	flash_bus_command_control #(.ERASE_PULSE_CYCLES(20)) dut_u (
		.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp(resp), .vpp_enable(vpp_enable),
		.vpp_high(vpp_high), .pins(pins), .data_lines_in(data_lines_in));

	flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) model_u (
		.pins(pins), .clk(clk), .vpp_high(vpp_high), .data_lines_in(data_lines_in));

	always #10 clk = ~clk;

	task results;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			$display("[ERR] %0t run did not finish", $time);
			results();
		end
	end

	// While the host drives data, the chip is selected for a write, gate high
	always @(posedge clk) begin
		if (!rst && (pins.data_drive_n === 1'b0 || pins.we_n === 1'b0)) begin
			samples_checked++;
			if (!(pins.data_drive_n === 1'b0 && pins.oe_n === 1'b1 && pins.ce_n === 1'b0
				&& vpp_high === 1'b1)) begin
				err_total++;
				$display("[ERR] %0t bad write strobe framing", $time);
			end
		end
	end

	task chk(input logic [15:0] g, input logic [15:0] e, input string what);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, g, e);
		end
	endtask

	task run(input flash_host_pkg::op_e op, input logic [16:0] a, input logic [7:0] d);
		int n;
		logic refuse;
		n = 0;
		refuse = (vpp_ref == 0) && !(op == flash_host_pkg::OP_READ
			|| op == flash_host_pkg::OP_READ_ID_HV);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, data: d};
		#1;
		chk({15'h0, req_ready}, 16'h0001, "ready when idle");
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		while (resp_valid !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 2000) begin
			err_total++;
			$display("[ERR] %0t no response", $time);
		end
		got = resp;
		chk({15'h0, req_ready}, 16'h0000, "ready while answering");
		chk({15'h0, got.refused}, {15'h0, refuse}, "refused");
		if (!refuse) begin
			case (op)
				flash_host_pkg::OP_READ: chk(got.data, {8'h00, 8'(ref_mem[a[7:0]])}, "read");
				flash_host_pkg::OP_READ_ID_HV: chk(got.data, {MAKER, DEVICE}, "id hv");
				flash_host_pkg::OP_READ_ID_CMD: chk(got.data, {MAKER, DEVICE}, "id cmd");
				flash_host_pkg::OP_ERASE: for (int i = 0; i < 256; i++) ref_mem[i] = 'hFF;
				flash_host_pkg::OP_PROGRAM: ref_mem[a[7:0]] = ref_mem[a[7:0]] & d;
				flash_host_pkg::OP_ERASE_VERIFY: begin
					chk(got.data, {8'h00, 8'(ref_mem[a[7:0]])}, "erase verify data");
					chk({15'h0, got.verify_ok}, {15'h0, ref_mem[a[7:0]] == 'hFF}, "erase ok");
				end
				flash_host_pkg::OP_PROGRAM_VERIFY: begin
					chk(got.data, {8'h00, 8'(ref_mem[a[7:0]])}, "prog verify data");
					chk({15'h0, got.verify_ok}, {15'h0, ref_mem[a[7:0]] == d}, "prog ok");
				end
				default: ;
			endcase
		end
	endtask

	task set_vpp(input logic v);
		@(posedge clk);
		vpp_enable <= v;
		repeat (3) @(posedge clk);
		vpp_ref = v;
		chk({15'h0, vpp_high}, {15'h0, v}, "supply level");
	endtask

	initial begin
		void'($urandom(28408));
		for (int i = 0; i < 256; i++) ref_mem[i] = i ^ 'h5A;
		for (int k = 0; k < 3; k++) begin
			pa[k] = 17'($urandom_range(255, 2));
			pd[k] = 8'($urandom);
		end
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		run(flash_host_pkg::OP_READ, pa[0], 8'h00);
		run(flash_host_pkg::OP_READ_ID_HV, 17'h00000, 8'h00);
		run(flash_host_pkg::OP_PROGRAM, pa[0], 8'h00);
		run(flash_host_pkg::OP_READ, pa[0], 8'h00);
		$display("test supply low done");
		set_vpp(1'b1);
		run(flash_host_pkg::OP_READ_ID_CMD, 17'h00000, 8'h00);
		run(flash_host_pkg::OP_READ_ARRAY, 17'h00000, 8'h00);
		run(flash_host_pkg::OP_READ, pa[1], 8'h00);
		$display("test identifier done");
		run(flash_host_pkg::OP_ERASE, 17'h00000, 8'h00);
		for (int k = 0; k < 3; k++) begin
			run(flash_host_pkg::OP_ERASE_VERIFY, pa[k], 8'h00);
			run(flash_host_pkg::OP_PROGRAM, pa[k], pd[k]);
			run(flash_host_pkg::OP_PROGRAM_VERIFY, pa[k], pd[k]);
		end
		$display("test erase and program done");
		run(flash_host_pkg::OP_RESET, 17'h00000, 8'h00);
		run(flash_host_pkg::OP_CMD_WRITE, 17'h00000, 8'h00);
		for (int k = 0; k < 3; k++) run(flash_host_pkg::OP_READ, pa[k], 8'h00);
		$display("test read back done");
		set_vpp(1'b0);
		run(flash_host_pkg::OP_ERASE, 17'h00000, 8'h00);
		run(flash_host_pkg::OP_READ, pa[2], 8'h00);
		$display("test protection done");
		results();
	end
endmodule
